//--- verilog/temp_monitor_pkg.sv
// Package for the three-channel temperature monitor control and status block.
// Assumes a byte-wide register port and a converter on the same clock.
package temp_monitor_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [7:0] ADDR_STATUS_FLAGS      = 8'h02;
	localparam logic [7:0] ADDR_MAIN_CONTROL_RD   = 8'h03;
	localparam logic [7:0] ADDR_MAIN_CONTROL_WR   = 8'h09;
	localparam logic [7:0] ADDR_EXTENDED_CONTROL  = 8'h04;
	localparam logic [7:0] ADDR_SINGLE_CONVERSION = 8'h0F;
	localparam logic [7:0] ADDR_DIODE_ONE_IDEAL   = 8'h27;
	localparam logic [7:0] ADDR_DIODE_TWO_IDEAL   = 8'h28;
	localparam logic [7:0] ADDR_PART_IDENTIFIER   = 8'hED;
	localparam logic [7:0] ADDR_MAKER_IDENTIFIER  = 8'hFE;
	localparam logic [7:0] ADDR_DIE_REVISION      = 8'hFF;
	localparam logic [7:0] ADDR_INT_TEMP_HIGH     = 8'h00;
	localparam logic [7:0] ADDR_INT_TEMP_LOW      = 8'h29;
	localparam logic [7:0] ADDR_D1_TEMP_HIGH      = 8'hFA;
	localparam logic [7:0] ADDR_D1_TEMP_LOW       = 8'hFB;
	localparam logic [7:0] ADDR_D2_TEMP_HIGH      = 8'hFC;
	localparam logic [7:0] ADDR_D2_TEMP_LOW       = 8'hFD;

	// ==========================================================
	// Field positions
	localparam int STATUS_BUSY_BIT      = 7;
	localparam int STATUS_HOTTER_BIT    = 4;
	localparam int STATUS_D2_FAULT_BIT  = 1;
	localparam int STATUS_D1_FAULT_BIT  = 0;
	localparam int MAIN_HALT_BIT        = 6;
	localparam int MAIN_RATE_LSB        = 0;
	localparam int EXT_EXTRA_RES_BIT    = 3;
	localparam int EXT_AVG_OFF_BIT      = 2;
	localparam int EXT_HOTTER_MODE_BIT  = 1;
	localparam int EXT_SERIES_FIX_BIT   = 0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] MAIN_CONTROL_RESET     = 8'h45;
	localparam logic [7:0] EXTENDED_CONTROL_RESET = 8'h09;
	localparam logic [5:0] IDEALITY_RESET         = 6'h12;

	// ==========================================================
	// Rate codes, resolutions, channels
	localparam logic [2:0] RATE_1_PER_S  = 3'h3;
	localparam logic [2:0] RATE_8_PER_S  = 3'h6;
	localparam logic [2:0] RATE_16_PER_S = 3'h7;
	localparam logic [3:0] RES_11_BITS   = 4'hB;
	localparam logic [3:0] RES_12_BITS   = 4'hC;
	localparam logic [3:0] RES_13_BITS   = 4'hD;
	localparam logic [1:0] CH_INTERNAL   = 2'h0;
	localparam logic [1:0] CH_DIODE_ONE  = 2'h1;
	localparam logic [1:0] CH_DIODE_TWO  = 2'h2;

	// ==========================================================
	// Timing
	localparam int SECOND_NS         = 1000000000;
	localparam int CLK_PERIOD_NS     = 20;
	localparam int CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;
	localparam int TIMER_WIDTH       = 26;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_WAIT,
		PH_START,
		PH_CONVERT
	} phase_e;

endpackage

//--- verilog/temp_monitor_control_status.sv
// Control and status logic of a three-channel temperature monitor.
// Assumes a serial bus engine issuing one-cycle register strobes and an
// analog converter answering each start with one done pulse, same clock.
`timescale 1ns/1ps

module temp_monitor_control_status
	import temp_monitor_pkg::*;
#(
	parameter int          CYCLES_PER_S = CYCLES_PER_SECOND,
	parameter logic [7:0]  PART_ID      = 8'h3C,
	parameter logic [7:0]  MAKER_ID     = 8'hA7,
	parameter logic [3:0]  REVISION_ID  = 4'h1
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             adc_start,
	output logic      [1:0]  adc_channel,
	output logic      [3:0]  adc_resolution,
	input  wire logic        adc_done,
	input  wire logic [10:0] adc_result,
	input  wire logic        adc_fault,
	output logic             series_resistance_fix,
	output logic      [5:0]  diode_one_ideality_code,
	output logic      [5:0]  diode_two_ideality_code,
	output logic             standby
);

	// PART_ID, MAKER_ID and REVISION_ID defaults are arbitrary values.

	// ==========================================================
	// State
	typedef struct packed {
		logic                   halt;
		logic [2:0]             rate_select;
		logic                   extra_resolution;
		logic                   averaging_off;
		logic                   hotter_mode;
		logic                   series_fix;
		logic [5:0]             ideal_one;
		logic [5:0]             ideal_two;
		logic                   diode_one_fault;
		logic                   diode_two_fault;
		logic                   d2_hotter;
		logic [10:0]            temp_int;
		logic [10:0]            temp_d1;
		logic [10:0]            temp_d2;
		logic [7:0]             low_int;
		logic [7:0]             low_d1;
		logic [7:0]             low_d2;
		logic                   oneshot_pend;
		phase_e                 phase;
		logic [1:0]             channel;
		logic [TIMER_WIDTH-1:0] timer;
		logic [7:0]             rdata;
		logic                   start;
		logic [3:0]             resolution;
	} state_s;

	state_s cur;
	state_s next_s;

	// ==========================================================
	// Functions
	function automatic logic [TIMER_WIDTH-1:0] period_cycles(
		input logic [2:0] rate);
		int shift;
		shift = (rate < RATE_1_PER_S) ? 0 : int'(rate - RATE_1_PER_S);
		return TIMER_WIDTH'(CYCLES_PER_S >> shift);
	endfunction

	function automatic logic [3:0] resolution_for(
		input logic avg_off, input logic extra, input logic [2:0] rate);
		logic [3:0] res;
		res = RES_12_BITS;
		if (avg_off || rate == RATE_16_PER_S) begin
			res = RES_11_BITS;
		end else if (extra && rate != RATE_8_PER_S) begin
			res = RES_13_BITS;
		end
		return res;
	endfunction

	function automatic logic [7:0] high_byte(input logic [10:0] t);
		return t[10:3];
	endfunction

	function automatic logic [7:0] low_byte(input logic [10:0] t);
		return {t[2:0], 5'h00};
	endfunction

	// ==========================================================
	// Next state
	logic             busy;
	logic [7:0]       status_value;
	logic [7:0]       main_value;
	logic [7:0]       ext_value;
	logic             cycle_go;
	logic [10:0]      d2_load;

	always_comb begin
		next_s = cur;
		busy = (cur.phase == PH_START) || (cur.phase == PH_CONVERT);
		status_value = 8'h00;
		status_value[STATUS_BUSY_BIT] = busy;
		status_value[STATUS_HOTTER_BIT] = cur.hotter_mode
			& cur.d2_hotter;
		status_value[STATUS_D2_FAULT_BIT] = cur.diode_two_fault;
		status_value[STATUS_D1_FAULT_BIT] = cur.diode_one_fault;
		main_value = 8'h00;
		main_value[MAIN_HALT_BIT] = cur.halt;
		main_value[MAIN_RATE_LSB +: 3] = cur.rate_select;
		ext_value = 8'h00;
		ext_value[EXT_EXTRA_RES_BIT] = cur.extra_resolution;
		ext_value[EXT_AVG_OFF_BIT] = cur.averaging_off;
		ext_value[EXT_HOTTER_MODE_BIT] = cur.hotter_mode;
		ext_value[EXT_SERIES_FIX_BIT] = cur.series_fix;
		d2_load = adc_result;

		// Register reads, answer one cycle after the strobe
		next_s.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_STATUS_FLAGS:      next_s.rdata = status_value;
				ADDR_MAIN_CONTROL_RD:   next_s.rdata = main_value;
				ADDR_EXTENDED_CONTROL:  next_s.rdata = ext_value;
				ADDR_SINGLE_CONVERSION: next_s.rdata = 8'h00;
				ADDR_DIODE_ONE_IDEAL:   next_s.rdata = {2'b00, cur.ideal_one};
				ADDR_DIODE_TWO_IDEAL:   next_s.rdata = {2'b00, cur.ideal_two};
				ADDR_PART_IDENTIFIER:   next_s.rdata = PART_ID;
				ADDR_MAKER_IDENTIFIER:  next_s.rdata = MAKER_ID;
				ADDR_DIE_REVISION:      next_s.rdata = {4'h0, REVISION_ID};
				ADDR_INT_TEMP_HIGH: begin
					next_s.rdata = high_byte(cur.temp_int);
					next_s.low_int = low_byte(cur.temp_int);
				end
				ADDR_INT_TEMP_LOW:      next_s.rdata = cur.low_int;
				ADDR_D1_TEMP_HIGH: begin
					next_s.rdata = high_byte(cur.temp_d1);
					next_s.low_d1 = low_byte(cur.temp_d1);
				end
				ADDR_D1_TEMP_LOW:       next_s.rdata = cur.low_d1;
				ADDR_D2_TEMP_HIGH: begin
					next_s.rdata = high_byte(cur.temp_d2);
					next_s.low_d2 = low_byte(cur.temp_d2);
				end
				ADDR_D2_TEMP_LOW:       next_s.rdata = cur.low_d2;
				default:                next_s.rdata = 8'h00;
			endcase
		end

		// Register writes; other addresses are ignored
		if (reg_wr) begin
			case (reg_addr)
				ADDR_MAIN_CONTROL_WR: begin
					next_s.halt = reg_wdata[MAIN_HALT_BIT];
					next_s.rate_select = reg_wdata[MAIN_RATE_LSB +: 3];
				end
				ADDR_EXTENDED_CONTROL: begin
					next_s.extra_resolution = reg_wdata[EXT_EXTRA_RES_BIT];
					next_s.averaging_off = reg_wdata[EXT_AVG_OFF_BIT];
					next_s.hotter_mode = reg_wdata[EXT_HOTTER_MODE_BIT];
					next_s.series_fix = reg_wdata[EXT_SERIES_FIX_BIT];
				end
				ADDR_SINGLE_CONVERSION: next_s.oneshot_pend = 1'b1;
				ADDR_DIODE_ONE_IDEAL:   next_s.ideal_one = reg_wdata[5:0];
				ADDR_DIODE_TWO_IDEAL:   next_s.ideal_two = reg_wdata[5:0];
				default: ;
			endcase
		end

		// Conversion sequencer
		next_s.start = 1'b0;
		next_s.timer = cur.timer + 1'b1;
		cycle_go = 1'b0;
		case (cur.phase)
			PH_IDLE: begin
				next_s.timer = '0;
				if (cur.oneshot_pend || !cur.halt) begin
					cycle_go = 1'b1;
				end
			end
			PH_WAIT: begin
				if (cur.oneshot_pend
					|| cur.timer >= period_cycles(cur.rate_select) - 1'b1) begin
					cycle_go = 1'b1;
				end else if (cur.halt) begin
					next_s.phase = PH_IDLE;
				end
			end
			PH_START: begin
				next_s.start = 1'b1;
				next_s.phase = PH_CONVERT;
			end
			PH_CONVERT: begin
				if (adc_done) begin
					case (cur.channel)
						CH_INTERNAL: begin
							if (!adc_fault) begin
								next_s.temp_int = adc_result;
							end
						end
						CH_DIODE_ONE: begin
							next_s.diode_one_fault = adc_fault;
							if (!adc_fault) begin
								next_s.temp_d1 = adc_result;
							end
						end
						default: begin
							next_s.diode_two_fault = adc_fault;
							if (cur.hotter_mode && !cur.diode_one_fault
								&& ($signed(cur.temp_d1)
								> $signed(adc_result) || adc_fault)) begin
								d2_load = cur.temp_d1;
								next_s.d2_hotter = 1'b0;
							end else begin
								next_s.d2_hotter = !adc_fault;
							end
							if (!adc_fault || (cur.hotter_mode
								&& !cur.diode_one_fault)) begin
								next_s.temp_d2 = d2_load;
							end
						end
					endcase
					if (cur.channel == CH_DIODE_TWO) begin
						next_s.phase = cur.halt ? PH_IDLE : PH_WAIT;
					end else begin
						next_s.channel = cur.channel + 1'b1;
						next_s.phase = PH_START;
					end
				end
			end
			default: next_s.phase = PH_IDLE;
		endcase
		if (cycle_go) begin
			next_s.phase = PH_START;
			next_s.channel = CH_INTERNAL;
			next_s.timer = '0;
			next_s.oneshot_pend = reg_wr
				&& reg_addr == ADDR_SINGLE_CONVERSION;
		end

		next_s.resolution = resolution_for(cur.averaging_off,
			cur.extra_resolution, cur.rate_select);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
			cur.halt <= MAIN_CONTROL_RESET[MAIN_HALT_BIT];
			cur.rate_select <= MAIN_CONTROL_RESET[MAIN_RATE_LSB +: 3];
			cur.extra_resolution <= EXTENDED_CONTROL_RESET[EXT_EXTRA_RES_BIT];
			cur.averaging_off <= EXTENDED_CONTROL_RESET[EXT_AVG_OFF_BIT];
			cur.hotter_mode <= EXTENDED_CONTROL_RESET[EXT_HOTTER_MODE_BIT];
			cur.series_fix <= EXTENDED_CONTROL_RESET[EXT_SERIES_FIX_BIT];
			cur.ideal_one <= IDEALITY_RESET;
			cur.ideal_two <= IDEALITY_RESET;
			cur.phase <= PH_IDLE;
			cur.resolution <= RES_12_BITS;
		end else begin
			cur <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata = cur.rdata;
	assign adc_start = cur.start;
	assign adc_channel = cur.channel;
	assign adc_resolution = cur.resolution;
	assign series_resistance_fix = cur.series_fix;
	assign diode_one_ideality_code = cur.ideal_one;
	assign diode_two_ideality_code = cur.ideal_two;
	assign standby = cur.halt;

	// ==========================================================
	// Assertions
	property p_oneshot_reads_zero;
		@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && reg_addr == ADDR_SINGLE_CONVERSION |=> reg_rdata == 8'h00;
	endproperty
	a_oneshot_reads_zero: assert property (p_oneshot_reads_zero)
		else $error("one-shot address read nonzero");

	property p_undefined_reads_zero;
		@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && reg_addr == 8'h01 |=> reg_rdata == 8'h00;
	endproperty
	a_undefined_reads_zero: assert property (p_undefined_reads_zero)
		else $error("undefined address read nonzero");

	property p_halt_idle_quiet;
		@(posedge sys_clk) disable iff (!rst_n)
		cur.phase == PH_IDLE && cur.halt && !cur.oneshot_pend
			&& !reg_wr |=> ##1 !adc_start;
	endproperty
	a_halt_idle_quiet: assert property (p_halt_idle_quiet)
		else $error("conversion started while halted");

	property p_config_alias;
		@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == ADDR_MAIN_CONTROL_WR ##1 reg_rd
			&& reg_addr == ADDR_MAIN_CONTROL_RD
			|=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2);
	endproperty
	a_config_alias: assert property (p_config_alias)
		else $error("main control readback differs from write");

	property p_averaging_off_res;
		@(posedge sys_clk) disable iff (!rst_n)
		cur.averaging_off |=> adc_resolution == RES_11_BITS;
	endproperty
	a_averaging_off_res: assert property (p_averaging_off_res)
		else $error("resolution not fixed with averaging off");

	property p_extra_res_slow;
		@(posedge sys_clk) disable iff (!rst_n)
		!cur.averaging_off && cur.extra_resolution
			&& cur.rate_select < RATE_8_PER_S
			|=> adc_resolution == RES_13_BITS;
	endproperty
	a_extra_res_slow: assert property (p_extra_res_slow)
		else $error("slow rates should give 13 bits");

	property p_normal_mode_hotter_zero;
		@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && reg_addr == ADDR_STATUS_FLAGS && !cur.hotter_mode
			|=> reg_rdata[STATUS_HOTTER_BIT] == 1'b0;
	endproperty
	a_normal_mode_hotter_zero: assert property (p_normal_mode_hotter_zero)
		else $error("hotter bit set in normal mode");

	property p_fault_keeps_data;
		@(posedge sys_clk) disable iff (!rst_n)
		cur.phase == PH_CONVERT && adc_done && adc_fault
			&& cur.channel == CH_DIODE_ONE
			|=> $stable(cur.temp_d1) && cur.diode_one_fault;
	endproperty
	a_fault_keeps_data: assert property (p_fault_keeps_data)
		else $error("diode fault altered data or missed flag");

	property p_start_then_busy;
		@(posedge sys_clk) disable iff (!rst_n)
		adc_start ##0 reg_rd && reg_addr == ADDR_STATUS_FLAGS
			|=> reg_rdata[STATUS_BUSY_BIT];
	endproperty
	a_start_then_busy: assert property (p_start_then_busy)
		else $error("busy clear during conversion");

endmodule

//--- verif/adc_model.sv
// Behavioural converter answering the block's start pulses.
// Assumes the bench sets res and flt hierarchically before a conversion.
`timescale 1ns/1ps
module adc_model #(
	parameter int DELAY = 2
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        adc_start,
	input  wire logic [1:0]  adc_channel,
	output logic             adc_done,
	output logic      [10:0] adc_result,
	output logic             adc_fault
);
	logic [10:0] res [3];
	logic [2:0]  flt;
	logic [1:0]  ch;
	logic [1:0]  exp_ch;
	logic        pend;
	int          wait_cnt;
	int          cyc;
	int          ch0_starts;
	int          last_t;
	int          prev_t;
	int          seq_err;

	// ==========================================================
	// Conversion timing and channel order bookkeeping
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			adc_done <= 1'b0;
			adc_result <= 11'h000;
			adc_fault <= 1'b0;
			pend <= 1'b0;
			ch <= 2'h0;
			exp_ch <= 2'h0;
			wait_cnt <= 0;
			cyc <= 0;
			ch0_starts <= 0;
			last_t <= 0;
			prev_t <= 0;
			seq_err <= 0;
		end else begin
			cyc <= cyc + 1;
			adc_done <= 1'b0;
			// Outside a done pulse the lines invert every cycle, so the stale value returns on alternate cycles
			adc_result <= ~adc_result;
			adc_fault <= ~adc_fault;
			if (adc_start) begin
				pend <= 1'b1;
				ch <= adc_channel;
				wait_cnt <= DELAY;
				if (adc_channel !== exp_ch)
					seq_err <= seq_err + 1;
				exp_ch <= (adc_channel == 2'h2) ? 2'h0 : adc_channel + 2'h1;
				if (adc_channel == 2'h0) begin
					prev_t <= last_t;
					last_t <= cyc;
					ch0_starts <= ch0_starts + 1;
				end
			end else if (pend) begin
				if (wait_cnt == 1) begin
					pend <= 1'b0;
					adc_done <= 1'b1;
					adc_result <= res[ch];
					adc_fault <= flt[ch];
				end
				wait_cnt <= wait_cnt - 1;
			end
		end
	end
endmodule

//--- verif/temp_monitor_control_status_tb.sv
// Self-checking bench for the temperature monitor control and status block.
// Assumes the converter model in adc_model.sv and a 50 MHz clock.
`timescale 1ns/1ps
module temp_monitor_control_status_tb;
	import temp_monitor_pkg::*;
	localparam int         CPS   = 256;
	localparam logic [7:0] PID_V = 8'h6B; // Arbitrary value
	localparam logic [7:0] MID_V = 8'h2C; // Arbitrary value
	localparam logic [3:0] REV_V = 4'h3;  // Arbitrary value
	logic        sys_clk, rst_n, reg_wr, reg_rd, adc_start, adc_done;
	logic        adc_fault, series_resistance_fix, standby;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
	logic [1:0]  adc_channel;
	logic [3:0]  adc_resolution;
	logic [10:0] adc_result;
	logic [5:0]  diode_one_ideality_code, diode_two_ideality_code;
	int          miscompares = 0;
	int          checked = 0;

	temp_monitor_control_status #(.CYCLES_PER_S(CPS), .PART_ID(PID_V),
		.MAKER_ID(MID_V), .REVISION_ID(REV_V)) u_temp_monitor_control_status (
		.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .adc_start(adc_start),
		.adc_channel(adc_channel), .adc_resolution(adc_resolution),
		.adc_done(adc_done), .adc_result(adc_result), .adc_fault(adc_fault),
		.series_resistance_fix(series_resistance_fix),
		.diode_one_ideality_code(diode_one_ideality_code),
		.diode_two_ideality_code(diode_two_ideality_code),
		.standby(standby));
	adc_model u_adc_model (.sys_clk(sys_clk), .rst_n(rst_n),
		.adc_start(adc_start), .adc_channel(adc_channel),
		.adc_done(adc_done), .adc_result(adc_result), .adc_fault(adc_fault));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// Bus, compare and closing tasks
	task final_report();
		if (miscompares == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task timeout();
		miscompares++;
		final_report();
	endtask
	task check(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task check_count(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %0d seen %0d", name, exp, got);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		// Let the write settle before outputs are looked at
		#1;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		check($sformatf("reg %h", a), exp, v);
	endtask
	task one_shot();
		int i;
		wr(8'h0F, 8'hA5);
		rd(8'h02, d);
		check("busy", 8'h01, {7'h0, d[7]});
		for (i = 0; i < 40 && d[7] !== 1'b0; i++)
			rd(8'h02, d);
		if (d[7] !== 1'b0)
			timeout();
		rd_chk(8'h0F, 8'h00);
	endtask
	task wait_starts(input int n);
		int i;
		for (i = 0; i < 1000 && u_adc_model.ch0_starts < n; i++)
			@(posedge sys_clk);
		if (u_adc_model.ch0_starts < n)
			timeout();
	endtask
	function automatic logic [3:0] exp_res(logic off, logic ex, logic [2:0] r);
		if (off || r == 3'h7)
			return 4'hB;
		if (r == 3'h6 || !ex)
			return 4'hC;
		return 4'hD;
	endfunction

	// ==========================================================
	// Scenarios
	task t_regs();
		logic [7:0] a [10] = '{8'h02, 8'h03, 8'h04, 8'h27, 8'h28, 8'h0F,
			8'hED, 8'hFE, 8'hFF, 8'h05};
		logic [7:0] e [10] = '{8'h00, 8'h45, 8'h09, 8'h12, 8'h12, 8'h00,
			PID_V, MID_V, {4'h0, REV_V}, 8'h00};
		for (int i = 0; i < 10; i++)
			rd_chk(a[i], e[i]);
		check("standby", 8'h01, {7'h0, standby});
		check("series fix", 8'h01, {7'h0, series_resistance_fix});
		check("ideal one", 8'h12, {2'h0, diode_one_ideality_code});
		wr(8'h03, 8'h00);
		rd_chk(8'h03, 8'h45);
		wr(8'hED, 8'h00);
		wr(8'hFE, 8'h00);
		rd_chk(8'hED, PID_V);
		rd_chk(8'hFE, MID_V);
		wr(8'h05, 8'hFF);
		rd_chk(8'h05, 8'h00);
		wr(8'h27, 8'h3F);
		wr(8'h28, 8'h00);
		rd_chk(8'h27, 8'h3F);
		rd_chk(8'h28, 8'h00);
		check("ideal one", 8'h3F, {2'h0, diode_one_ideality_code});
		check("ideal two", 8'h00, {2'h0, diode_two_ideality_code});
		wr(8'h04, 8'h08);
		check("series fix", 8'h00, {7'h0, series_resistance_fix});
		wr(8'h04, 8'h09);
		check("series fix", 8'h01, {7'h0, series_resistance_fix});
	endtask
	task t_alias();
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= 8'h09;
		reg_wdata <= 8'h46;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= 8'h03;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		check("alias", 8'h46, d);
		rd_chk(8'h01, 8'h00);
		wr(8'h09, 8'h45);
	endtask
	task t_resolution();
		logic [7:0] c;
		for (int k = 0; k < 20; k++) begin
			c = {4'h0, k[1], k[0], 2'b01};
			wr(8'h04, c);
			wr(8'h09, 8'h40 | (3'h3 + k[4:2]));
			repeat (3) @(posedge sys_clk);
			check("resolution", {4'h0, exp_res(k[0], k[1], 3'h3 + k[4:2])},
				{4'h0, adc_resolution});
			rd_chk(8'h04, c);
			rd_chk(8'h03, 8'h40 | (3'h3 + k[4:2]));
		end
		wr(8'h04, 8'h09);
		wr(8'h09, 8'h45);
	endtask
	task t_data();
		u_adc_model.res = '{11'h3A5, 11'h2F1, 11'h1C6};
		u_adc_model.flt = 3'h0;
		one_shot();
		rd_chk(8'h00, 8'h74);
		rd_chk(8'h29, 8'hA0);
		rd_chk(8'hFA, 8'h5E);
		u_adc_model.res[1] = 11'h10F;
		one_shot();
		rd_chk(8'hFB, 8'h20);
		rd_chk(8'hFC, 8'h38);
		rd_chk(8'hFD, 8'hC0);
	endtask
	task t_fault();
		u_adc_model.flt = 3'h2;
		u_adc_model.res[1] = 11'h0AA;
		one_shot();
		rd_chk(8'h02, 8'h01);
		rd_chk(8'hFA, 8'h21);
		u_adc_model.flt = 3'h4;
		u_adc_model.res[2] = 11'h055;
		one_shot();
		rd_chk(8'h02, 8'h02);
		rd_chk(8'hFC, 8'h38);
		u_adc_model.flt = 3'h0;
	endtask
	task t_hotter();
		wr(8'h04, 8'h0B);
		u_adc_model.res = '{11'h100, 11'h300, 11'h200};
		one_shot();
		rd_chk(8'h02, 8'h00);
		rd_chk(8'hFC, 8'h60);
		u_adc_model.res[2] = 11'h380;
		one_shot();
		rd_chk(8'h02, 8'h10);
		rd_chk(8'hFC, 8'h70);
		rd_chk(8'hFA, 8'h60);
		rd_chk(8'h00, 8'h20);
		wr(8'h04, 8'h09);
		one_shot();
		rd_chk(8'h02, 8'h00);
	endtask
	task t_rate();
		int n;
		for (int r = 7; r >= 3; r--) begin
			wr(8'h09, 8'(r));
			check("standby", 8'h00, {7'h0, standby});
			n = u_adc_model.ch0_starts;
			wait_starts(n + 3);
			check_count("period", CPS >> (r - 3),
				u_adc_model.last_t - u_adc_model.prev_t);
		end
		wr(8'h09, 8'h45);
		repeat (60) @(posedge sys_clk);
		n = u_adc_model.ch0_starts;
		repeat (600) @(posedge sys_clk);
		check_count("halted starts", n, u_adc_model.ch0_starts);
		check("standby", 8'h01, {7'h0, standby});
		rd_chk(8'h02, 8'h00);
	endtask

	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_regs();
		t_alias();
		t_resolution();
		t_data();
		t_fault();
		t_hotter();
		t_rate();
		check("channel order", 8'h00, 8'(u_adc_model.seq_err));
		final_report();
	end
endmodule
